/* File: tsif_params.svh */
// offsets, field positions, reset values and masks of the triple slave if
`ifndef TSIF_PARAMS_SVH
`define TSIF_PARAMS_SVH
// ----------------------------------------------------------------------
// register indices on the device port (axi byte address = index * 4)
// ----------------------------------------------------------------------
`define TSIF_IDX_CR1 3'h0
`define TSIF_IDX_CR2 3'h1
`define TSIF_IDX_STAT 3'h2
`define TSIF_IDX_CNT 3'h3
`define TSIF_IDX_SAR1 3'h4
`define TSIF_IDX_IRQ 3'h5
// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define TSIF_B_WR12_ON 0
`define TSIF_B_WR3_ON 1
`define TSIF_B_RD12_ON 2
`define TSIF_B_RD3_ON 3
`define TSIF_B_FAULT_ON 4
`define TSIF_B_WORD_LOCK 0
`define TSIF_B_WRITE_HOLD 1
`define TSIF_B_IFACE_ON 2
`define TSIF_B_LOCK1 3
`define TSIF_B_LOCK2 4
`define TSIF_B_MISPLACED 6
`define TSIF_B_OPEN_REJ 7
// ----------------------------------------------------------------------
// reset values, writable masks, page masks, bus answers
// ----------------------------------------------------------------------
`define TSIF_RST8 8'h00
`define TSIF_CR1_WMASK 8'hdf
`define TSIF_CR2_WMASK 8'h1f
`define TSIF_PM8 8'h07
`define TSIF_PM16 8'h0f
`define TSIF_PMFULL12 8'hff
`define TSIF_PMFULL3 8'h7f
`define TSIF_RESP_OKAY 2'h0
`define TSIF_RESP_SLVERR 2'h2
`endif

/* File: tsif_pkg.sv */
// types shared by both ends of the triple slave interface
package tsif_pkg;
  // slave selected by the sequencer's address match
  typedef enum logic [1:0] {TSIF_SL1, TSIF_SL2, TSIF_SL3} tsif_slave_t;
  // page length selector encoding
  typedef enum logic [1:0] {TSIF_PL8, TSIF_PL16, TSIF_PLFULL, TSIF_PLNA}
    tsif_pl_t;
  // controller sequencing states
  typedef enum logic [1:0] {TSIF_C_IDLE, TSIF_C_WR2, TSIF_C_RD1, TSIF_C_RD2}
    tsif_cst_t;
endpackage

/* File: tsif_reg_if.sv */
// register port between the controller and the triple slave device
`timescale 1ns/1ps
interface tsif_reg_if (
  input logic clk,
  input logic reset_n
);
  logic reg_wr;
  logic reg_rd;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic irq12;
  logic irq3;
  logic wake;
  modport device (
    input clk, reset_n, reg_wr, reg_rd, reg_addr, reg_wdata,
    output reg_rdata, irq12, irq3, wake
  );
  modport ctrl (
    input clk, reset_n, reg_rdata, irq12, irq3, wake,
    output reg_wr, reg_rd, reg_addr, reg_wdata
  );
endinterface

/* File: tsif_device.sv */
// triple slave interface: control, status, byte count and slave 1 address
//
// Overview of operation
// - read/write interrupts only after stop or restart
// - wr12_irq_on gates slaves 1,2; wr3_irq_on slave 3
// - rd enables gate reads; interrupts wake from wait
// - page_length_sel picks 8, 16 or full page
// - iface_on low clears all config and flags
// - fault_irq_on routes errors to owning line
// - lock bits block buffer writes, not reads
// - protected write still acked and counted
// - protected write: no interrupt, no write_hold
// - second iface_on write activates the rest
// - write_hold set after write; addresses refused
// - writing one keeps write_hold unchanged
// - word_lock set by software, cleared after word
// - software masks interrupts during word update
// - open_reject_flag on open_reject_flag without stop, read-clear
// - misplaced_cond_flag set; clock not held meanwhile
// - direction bit sets per-slave write/read flag
// - event flags read-clear only when bus idle
// - xfer_count restarts per address, counts, wraps after 255
// - slave 1 address and enable, cleared when off
// - software writes zero to reserved bits
// - slaves 1,2 share a line; slave 3 own
// - software saves state then writes write_hold zero
//
// Design decisions made here: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`include "tsif_params.svh"
module tsif_device (
  tsif_reg_if.device rif,
  input wire logic sa_seen,
  input wire tsif_pkg::tsif_slave_t sa_slave,
  input wire logic sa_dir,
  input wire logic byte_done,
  input wire logic stop_restart,
  input wire logic open_reject_flag_no_stop,
  input wire logic misplaced_cond,
  input wire logic err_slave3,
  input wire logic bus_busy,
  input wire logic word_done,
  output logic [7:0] page_mask12,
  output logic [7:0] page_mask3,
  output logic [2:0] ram_wr_allow,
  output logic addr_refuse,
  output logic scl_hold_allow,
  output logic [6:0] slave1_addr,
  output logic slave1_on,
  output logic active
);
  // ----------------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------------
  function automatic logic hit(input logic [2:0] a, input logic [2:0] i);
    hit = (a == i);
  endfunction

  function automatic logic [2:0] onehot(input tsif_pkg::tsif_slave_t s);
    onehot = (s == tsif_pkg::TSIF_SL1) ? 3'h1 :
             (s == tsif_pkg::TSIF_SL2) ? 3'h2 : 3'h4;
  endfunction

  // page mask for a selector; code 11 is illegal and treated as 8 bytes
  function automatic logic [7:0] pmask(input logic [1:0] pl,
                                       input logic [7:0] full);
    pmask = (pl == tsif_pkg::TSIF_PL16) ? `TSIF_PM16 :
            (pl == tsif_pkg::TSIF_PLFULL) ? full : `TSIF_PM8;
  endfunction

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  logic [7:0] cr1_ff, nxt_cr1;
  logic on_ff, nxt_on;
  logic active_ff, nxt_active;
  logic lock1_ff, nxt_lock1;
  logic lock2_ff, nxt_lock2;
  logic hold_ff, nxt_hold;
  logic wlock_ff, nxt_wlock;
  logic [7:0] stat_ff, nxt_stat;
  logic [5:0] arm_ff, nxt_arm;
  logic err3_ff, nxt_err3;
  logic [7:0] cnt_ff, nxt_cnt;
  logic [7:0] sar1_ff, nxt_sar1;
  logic in_xfer_ff, nxt_in_xfer;
  logic xwr_ff, nxt_xwr;
  tsif_pkg::tsif_slave_t xsl_ff, nxt_xsl;
  logic [7:0] rdata_ff, nxt_rdata;
  logic irq12_ff, irq3_ff, wake_ff;
  logic [7:0] pm12_ff, pm3_ff;
  logic [2:0] wr_allow_ff;
  logic refuse_ff, sclok_ff;

  // ----------------------------------------------------------------------
  // register port decode
  // ----------------------------------------------------------------------
  wire [7:0] wd = rif.reg_wdata;
  wire wr_cr1 = rif.reg_wr & hit(rif.reg_addr, `TSIF_IDX_CR1);
  wire wr_cr2 = rif.reg_wr & hit(rif.reg_addr, `TSIF_IDX_CR2);
  wire wr_sar1 = rif.reg_wr & hit(rif.reg_addr, `TSIF_IDX_SAR1);
  wire rd_stat = rif.reg_rd & hit(rif.reg_addr, `TSIF_IDX_STAT);
  // a cr2 write only loads the other bits once iface_on is already set
  wire wr_cr2_full = wr_cr2 & on_ff;

  // ----------------------------------------------------------------------
  // enable sequence and control register 2
  // ----------------------------------------------------------------------
  assign nxt_on = wr_cr2 ? wd[`TSIF_B_IFACE_ON] : on_ff;
  assign nxt_active = nxt_on & (active_ff | wr_cr2_full);
  assign nxt_lock1 = ~nxt_on ? 1'b0 :
                     wr_cr2_full ? wd[`TSIF_B_LOCK1] : lock1_ff;
  assign nxt_lock2 = ~nxt_on ? 1'b0 :
                     wr_cr2_full ? wd[`TSIF_B_LOCK2] : lock2_ff;
  // software write of word_lock wins over the hardware clear
  assign nxt_wlock = ~nxt_on ? 1'b0 :
                     wr_cr2_full ? wd[`TSIF_B_WORD_LOCK] :
                     word_done ? 1'b0 : wlock_ff;

  // ----------------------------------------------------------------------
  // transfer tracking; events are ignored until fully active
  // ----------------------------------------------------------------------
  wire sa_ev = sa_seen & active_ff;
  wire end_ev = stop_restart & active_ff & in_xfer_ff;
  wire x_prot = ((xsl_ff == tsif_pkg::TSIF_SL1) & lock1_ff) |
                ((xsl_ff == tsif_pkg::TSIF_SL2) & lock2_ff);
  wire wr_end_ok = end_ev & xwr_ff & ~x_prot;
  assign nxt_in_xfer = nxt_on & (sa_ev | (in_xfer_ff & ~stop_restart));
  assign nxt_xwr = sa_ev ? ~sa_dir : xwr_ff;
  assign nxt_xsl = sa_ev ? sa_slave : xsl_ff;

  // write_hold: hardware set wins over a software zero in the same cycle
  assign nxt_hold = ~nxt_on ? 1'b0 :
                    wr_end_ok ? 1'b1 :
                    (wr_cr2_full & ~wd[`TSIF_B_WRITE_HOLD]) ? 1'b0 :
                    hold_ff;

  // ----------------------------------------------------------------------
  // status flags and interrupt arming
  // ----------------------------------------------------------------------
  wire [2:0] sa_oh = onehot(sa_slave);
  wire [2:0] x_oh = onehot(xsl_ff);
  wire [7:0] set_vec = {open_reject_flag_no_stop & active_ff,
                        misplaced_cond & active_ff,
                        sa_ev & ~sa_dir ? sa_oh : 3'h0,
                        sa_ev & sa_dir ? sa_oh : 3'h0};
  // event flags survive a status read taken during a transfer
  wire [7:0] clr_vec = {{2{rd_stat}}, {6{rd_stat & ~bus_busy}}};
  wire [5:0] arm_set = ~end_ev ? 6'h00 :
                       xwr_ff ? (x_prot ? 6'h00 : {x_oh, 3'h0}) :
                       {3'h0, x_oh};
  assign nxt_stat = ~nxt_on ? `TSIF_RST8 :
                    (stat_ff & ~clr_vec) | set_vec;
  assign nxt_arm = ~nxt_on ? 6'h00 :
                   (arm_ff & ~clr_vec[5:0]) | arm_set;
  assign nxt_err3 = (open_reject_flag_no_stop | misplaced_cond) ? err_slave3 : err3_ff;

  // ----------------------------------------------------------------------
  // interrupt lines; pending events stay armed until read-cleared
  // ----------------------------------------------------------------------
  wire [5:0] ev = stat_ff[5:0] & arm_ff;
  wire err_any = stat_ff[`TSIF_B_OPEN_REJ] | stat_ff[`TSIF_B_MISPLACED];
  wire err_on = cr1_ff[`TSIF_B_FAULT_ON] & err_any;
  wire irq12_c = (cr1_ff[`TSIF_B_WR12_ON] & (ev[3] | ev[4])) |
                 (cr1_ff[`TSIF_B_RD12_ON] & (ev[0] | ev[1])) |
                 (err_on & ~err3_ff);
  wire irq3_c = (cr1_ff[`TSIF_B_WR3_ON] & ev[5]) |
                (cr1_ff[`TSIF_B_RD3_ON] & ev[2]) |
                (err_on & err3_ff);

  // ----------------------------------------------------------------------
  // config registers, byte count and read data
  // ----------------------------------------------------------------------
  assign nxt_cr1 = ~nxt_on ? `TSIF_RST8 :
                   wr_cr1 ? (wd & `TSIF_CR1_WMASK) : cr1_ff;
  assign nxt_sar1 = ~nxt_on ? `TSIF_RST8 : wr_sar1 ? wd : sar1_ff;
  // plain 8-bit count: no page limit, a new address restarts it
  assign nxt_cnt = ~nxt_on ? `TSIF_RST8 :
                   sa_ev ? `TSIF_RST8 :
                   (byte_done & active_ff) ? cnt_ff + 8'h01 : cnt_ff;
  wire [7:0] cr2_rd = {3'h0, lock2_ff, lock1_ff, on_ff, hold_ff, wlock_ff};
  wire [7:0] rd_mux = hit(rif.reg_addr, `TSIF_IDX_CR1) ? cr1_ff :
                      hit(rif.reg_addr, `TSIF_IDX_CR2) ? cr2_rd :
                      hit(rif.reg_addr, `TSIF_IDX_STAT) ? stat_ff :
                      hit(rif.reg_addr, `TSIF_IDX_CNT) ? cnt_ff :
                      hit(rif.reg_addr, `TSIF_IDX_SAR1) ? sar1_ff :
                      `TSIF_RST8;
  assign nxt_rdata = rif.reg_rd ? rd_mux : rdata_ff;

  // ----------------------------------------------------------------------
  // flip-flops
  // ----------------------------------------------------------------------
  always_ff @(posedge rif.clk or negedge rif.reset_n) begin
    if (!rif.reset_n) begin
      cr1_ff <= `TSIF_RST8;
      on_ff <= 1'b0;
      active_ff <= 1'b0;
      lock1_ff <= 1'b0;
      lock2_ff <= 1'b0;
      hold_ff <= 1'b0;
      wlock_ff <= 1'b0;
      stat_ff <= `TSIF_RST8;
      arm_ff <= 6'h00;
      err3_ff <= 1'b0;
      cnt_ff <= `TSIF_RST8;
      sar1_ff <= `TSIF_RST8;
      in_xfer_ff <= 1'b0;
      xwr_ff <= 1'b0;
      xsl_ff <= tsif_pkg::TSIF_SL1;
      rdata_ff <= `TSIF_RST8;
    end else begin
      cr1_ff <= nxt_cr1;
      on_ff <= nxt_on;
      active_ff <= nxt_active;
      lock1_ff <= nxt_lock1;
      lock2_ff <= nxt_lock2;
      hold_ff <= nxt_hold;
      wlock_ff <= nxt_wlock;
      stat_ff <= nxt_stat;
      arm_ff <= nxt_arm;
      err3_ff <= nxt_err3;
      cnt_ff <= nxt_cnt;
      sar1_ff <= nxt_sar1;
      in_xfer_ff <= nxt_in_xfer;
      xwr_ff <= nxt_xwr;
      xsl_ff <= nxt_xsl;
      rdata_ff <= nxt_rdata;
    end
  end

  // interrupt and wake outputs lag the state by one cycle; the other outputs are registered from next state
  always_ff @(posedge rif.clk or negedge rif.reset_n) begin
    if (!rif.reset_n) begin
      irq12_ff <= 1'b0;
      irq3_ff <= 1'b0;
      wake_ff <= 1'b0;
      pm12_ff <= `TSIF_PM8;
      pm3_ff <= `TSIF_PM8;
      wr_allow_ff <= 3'h0;
      refuse_ff <= 1'b1;
      sclok_ff <= 1'b1;
    end else begin
      irq12_ff <= irq12_c;
      irq3_ff <= irq3_c;
      wake_ff <= irq12_c | irq3_c;
      pm12_ff <= pmask(nxt_cr1[7:6], `TSIF_PMFULL12);
      pm3_ff <= pmask(nxt_cr1[7:6], `TSIF_PMFULL3);
      wr_allow_ff <= {1'b1, ~nxt_lock2, ~nxt_lock1} & {3{nxt_active}};
      refuse_ff <= nxt_hold | ~nxt_active;
      sclok_ff <= ~nxt_stat[`TSIF_B_MISPLACED];
    end
  end

  assign rif.reg_rdata = rdata_ff;
  assign rif.irq12 = irq12_ff;
  assign rif.irq3 = irq3_ff;
  assign rif.wake = wake_ff;
  assign page_mask12 = pm12_ff;
  assign page_mask3 = pm3_ff;
  assign ram_wr_allow = wr_allow_ff;
  assign addr_refuse = refuse_ff;
  assign scl_hold_allow = sclok_ff;
  assign slave1_addr = sar1_ff[7:1];
  assign slave1_on = sar1_ff[0];
  assign active = active_ff;
endmodule

/* File: tsif_ctrl.sv */
// controller end: axi4-lite slave driving the device register port
`timescale 1ns/1ps
`include "tsif_params.svh"
module tsif_ctrl (
  tsif_reg_if.ctrl rif,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq_out
);
  // ----------------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------------
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[7:5] == 3'h0) & (a[4:2] <= `TSIF_IDX_SAR1);
  endfunction

  logic aw_ff, w_ff, ar_ff;
  logic [7:0] awa_ff, ara_ff;
  logic [7:0] wd_ff;
  logic wst_ff;
  tsif_pkg::tsif_cst_t st_ff, nxt_st;
  logic wr_ff, rd_ff;
  logic [2:0] pa_ff;
  logic [7:0] pd_ff;
  logic bv_ff, rv_ff;
  logic [1:0] br_ff, rr_ff;
  logic [31:0] rdat_ff;
  logic wl_mask_ff, irq_ff;

  // ----------------------------------------------------------------------
  // request decode; reserved bits forced to zero before they leave
  // ----------------------------------------------------------------------
  wire [2:0] aw_idx = awa_ff[4:2];
  wire [2:0] ar_idx = ara_ff[4:2];
  wire [7:0] wmask = (aw_idx == `TSIF_IDX_CR1) ? `TSIF_CR1_WMASK :
                     (aw_idx == `TSIF_IDX_CR2) ? `TSIF_CR2_WMASK : 8'hff;
  wire [7:0] wd_clean = wd_ff & wmask;
  wire is_cr2 = aw_idx == `TSIF_IDX_CR2;
  wire do_wr = (st_ff == tsif_pkg::TSIF_C_IDLE) & aw_ff & w_ff & ~bv_ff;
  wire do_rd = (st_ff == tsif_pkg::TSIF_C_IDLE) & ~do_wr & ar_ff & ~rv_ff;
  wire wr_real = do_wr & mapped(awa_ff) & wst_ff;
  // an enabling cr2 write is sent twice so the second one activates
  wire wr_twice = wr_real & is_cr2 & wd_clean[`TSIF_B_IFACE_ON];
  wire rd_real = do_rd & mapped(ara_ff);
  wire irq_rd = do_rd & (ara_ff[7:5] == 3'h0) & (ar_idx == `TSIF_IDX_IRQ);
  wire [31:0] irq_word = {30'h0, rif.irq3, rif.irq12};

  always_comb begin
    nxt_st = st_ff;
    unique case (st_ff)
      tsif_pkg::TSIF_C_IDLE: begin
        if (wr_twice) begin
          nxt_st = tsif_pkg::TSIF_C_WR2;
        end else if (rd_real) begin
          nxt_st = tsif_pkg::TSIF_C_RD1;
        end
      end
      tsif_pkg::TSIF_C_WR2: nxt_st = tsif_pkg::TSIF_C_IDLE;
      tsif_pkg::TSIF_C_RD1: nxt_st = tsif_pkg::TSIF_C_RD2;
      tsif_pkg::TSIF_C_RD2: nxt_st = tsif_pkg::TSIF_C_IDLE;
    endcase
  end

  wire wr_done = (do_wr & ~wr_twice) | (st_ff == tsif_pkg::TSIF_C_WR2);
  wire rd_done = (do_rd & ~rd_real) | (st_ff == tsif_pkg::TSIF_C_RD2);
  wire [1:0] w_resp = mapped(awa_ff) ? `TSIF_RESP_OKAY : `TSIF_RESP_SLVERR;
  wire [1:0] r_resp = (rd_real | irq_rd | st_ff == tsif_pkg::TSIF_C_RD2) ?
                      `TSIF_RESP_OKAY : `TSIF_RESP_SLVERR;
  wire [31:0] r_word = (st_ff == tsif_pkg::TSIF_C_RD2) ?
                       {24'h0, rif.reg_rdata} :
                       irq_rd ? irq_word : 32'h0;
  // word update in progress: hold interrupts off until lock is dropped
  wire wl_set = wr_real & is_cr2 & wd_clean[`TSIF_B_WORD_LOCK];
  wire wl_clr = (wr_real & is_cr2 & ~wd_clean[`TSIF_B_WORD_LOCK]) |
                ((st_ff == tsif_pkg::TSIF_C_RD2) & (pa_ff == `TSIF_IDX_CR2) &
                 ~rif.reg_rdata[`TSIF_B_WORD_LOCK]);

  // ----------------------------------------------------------------------
  // axi channel capture and answers
  // ----------------------------------------------------------------------
  always_ff @(posedge rif.clk or negedge rif.reset_n) begin
    if (!rif.reset_n) begin
      aw_ff <= 1'b0;
      w_ff <= 1'b0;
      ar_ff <= 1'b0;
      awa_ff <= 8'h00;
      ara_ff <= 8'h00;
      wd_ff <= 8'h00;
      wst_ff <= 1'b0;
      bv_ff <= 1'b0;
      rv_ff <= 1'b0;
      br_ff <= `TSIF_RESP_OKAY;
      rr_ff <= `TSIF_RESP_OKAY;
      rdat_ff <= 32'h0;
    end else begin
      if (s_axi_awvalid & ~aw_ff) begin
        aw_ff <= 1'b1;
        awa_ff <= s_axi_awaddr;
      end else if (wr_done) begin
        aw_ff <= 1'b0;
      end
      if (s_axi_wvalid & ~w_ff) begin
        w_ff <= 1'b1;
        wd_ff <= s_axi_wdata[7:0];
        wst_ff <= s_axi_wstrb[0];
      end else if (wr_done) begin
        w_ff <= 1'b0;
      end
      if (s_axi_arvalid & ~ar_ff) begin
        ar_ff <= 1'b1;
        ara_ff <= s_axi_araddr;
      end else if (rd_done) begin
        ar_ff <= 1'b0;
      end
      if (wr_done) begin
        bv_ff <= 1'b1;
        br_ff <= w_resp;
      end else if (s_axi_bready) begin
        bv_ff <= 1'b0;
      end
      if (rd_done) begin
        rv_ff <= 1'b1;
        rr_ff <= r_resp;
        rdat_ff <= r_word;
      end else if (s_axi_rready) begin
        rv_ff <= 1'b0;
      end
    end
  end

  // device port drive and interrupt forwarding
  always_ff @(posedge rif.clk or negedge rif.reset_n) begin
    if (!rif.reset_n) begin
      st_ff <= tsif_pkg::TSIF_C_IDLE;
      wr_ff <= 1'b0;
      rd_ff <= 1'b0;
      pa_ff <= 3'h0;
      pd_ff <= 8'h00;
      wl_mask_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      wr_ff <= wr_real | (st_ff == tsif_pkg::TSIF_C_WR2);
      rd_ff <= rd_real;
      if (wr_real) begin
        pa_ff <= aw_idx;
        pd_ff <= wd_clean;
      end else if (rd_real) begin
        pa_ff <= ar_idx;
      end
      wl_mask_ff <= wl_set | (wl_mask_ff & ~wl_clr);
      irq_ff <= (rif.irq12 | rif.irq3) & ~wl_mask_ff;
    end
  end

  assign rif.reg_wr = wr_ff;
  assign rif.reg_rd = rd_ff;
  assign rif.reg_addr = pa_ff;
  assign rif.reg_wdata = pd_ff;
  assign s_axi_awready = ~aw_ff;
  assign s_axi_wready = ~w_ff;
  assign s_axi_arready = ~ar_ff;
  assign s_axi_bvalid = bv_ff;
  assign s_axi_bresp = br_ff;
  assign s_axi_rvalid = rv_ff;
  assign s_axi_rresp = rr_ff;
  assign s_axi_rdata = rdat_ff;
  assign irq_out = irq_ff;
endmodule

/* File: tsif_chk.sv */
// assertions on the register port between controller and device
`timescale 1ns/1ps
`include "tsif_params.svh"
module tsif_chk (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic irq12,
  input wire logic irq3,
  input wire logic wake
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // ---
  // shadow of iface_on and the enables
  // ---
  logic off_ff;
  logic [7:0] cr1_ff;
  wire wr2 = reg_wr && reg_addr == `TSIF_IDX_CR2;
  wire wr1 = reg_wr && reg_addr == `TSIF_IDX_CR1;
  wire en12 = |(cr1_ff & 8'h15);
  wire en3 = |(cr1_ff & 8'h1a);
  // cr1 writes land only once on, so the shadow skips them while off
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      off_ff <= 1'b1;
      cr1_ff <= 8'h00;
    end else if (wr2) begin
      off_ff <= !reg_wdata[`TSIF_B_IFACE_ON];
      if (!reg_wdata[`TSIF_B_IFACE_ON]) cr1_ff <= 8'h00;
    end else if (wr1 && !off_ff) begin
      cr1_ff <= reg_wdata;
    end
  end
  // ---
  // properties
  // ---
  property p_off_read;
    reg_rd && off_ff && reg_addr <= `TSIF_IDX_SAR1 |=> reg_rdata == 8'h00;
  endproperty
  a_off_read: assert property (p_off_read)
    else $error("register not clear while off");
  property p_off_irq;
    off_ff [*4] |-> !irq12 && !irq3;
  endproperty
  a_off_irq: assert property (p_off_irq)
    else $error("interrupt line high while off");
  property p_wake;
    $rose(irq12) || $rose(irq3) |-> ##[0:2] wake;
  endproperty
  a_wake: assert property (p_wake)
    else $error("wake missing after interrupt");
  property p_rsv1;
    reg_rd && reg_addr == `TSIF_IDX_CR1 |=> !reg_rdata[5];
  endproperty
  a_rsv1: assert property (p_rsv1)
    else $error("reserved cr1 bit reads one");
  property p_rsv2;
    reg_rd && reg_addr == `TSIF_IDX_CR2 |=> reg_rdata[7:5] == 3'h0;
  endproperty
  a_rsv2: assert property (p_rsv2)
    else $error("reserved cr2 bits read nonzero");
  property p_irq12_en;
    (!en12) [*3] |-> !irq12;
  endproperty
  a_irq12_en: assert property (p_irq12_en)
    else $error("shared line high with its enables off");
  property p_irq3_en;
    (!en3) [*3] |-> !irq3;
  endproperty
  a_irq3_en: assert property (p_irq3_en)
    else $error("slave 3 line high with its enables off");
  property p_one_op;
    !(reg_wr && reg_rd);
  endproperty
  a_one_op: assert property (p_one_op)
    else $error("read and write in one cycle");
  c_irq12: cover property (irq12 ##1 !irq12);
  c_irq3: cover property ($rose(irq3));
  c_stat: cover property (reg_rd && !off_ff && reg_addr == `TSIF_IDX_STAT);
endmodule

/* File: i2c_triple_slave_ctrl_status_tb_top.sv */
// bench joining controller and device across the register port
`timescale 1ns/1ps
`include "tsif_params.svh"
module i2c_triple_slave_ctrl_status_tb_top;
  typedef struct packed {logic [7:0] a, d, r, m12, m3;} tsif_row_t;
  localparam logic [5:0] SA = 6'h20, BY = 6'h10, SR = 6'h08;
  localparam logic [5:0] NK = 6'h04, MS = 6'h02, WD = 6'h01;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] awaddr, araddr, m12, m3;
  logic [31:0] wdata, rdata;
  logic awvalid, wvalid, bready, arvalid, rready, irq_out;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [5:0] ev;
  logic busy, dir, err3, active, refuse, scl_ok, s1_on;
  logic [2:0] wr_ok;
  logic [6:0] s1_addr;
  tsif_pkg::tsif_slave_t sl;
  int n_fail = 0;
  int total_checks = 0;
  tsif_row_t rows [6] = '{{8'h00, 8'hff, 8'hdf, 8'h07, 8'h07},
    {8'h00, 8'h40, 8'h40, 8'h0f, 8'h0f}, {8'h00, 8'h80, 8'h80, 8'hff, 8'h7f},
    {8'h00, 8'h00, 8'h00, 8'h07, 8'h07}, {8'h10, 8'ha5, 8'ha5, 8'h07, 8'h07},
    {8'h04, 8'h1e, 8'h1c, 8'h07, 8'h07}};
  // ---
  // the two ends, the port between them and its checker
  // ---
  tsif_reg_if rif (.clk(clk), .reset_n(reset_n));
  tsif_device u_tsif_device (.rif(rif), .sa_seen(ev[5]), .sa_slave(sl),
    .sa_dir(dir), .byte_done(ev[4]), .stop_restart(ev[3]),
    .open_reject_flag_no_stop(ev[2]), .misplaced_cond(ev[1]), .err_slave3(err3),
    .bus_busy(busy), .word_done(ev[0]), .page_mask12(m12), .page_mask3(m3),
    .ram_wr_allow(wr_ok), .addr_refuse(refuse), .scl_hold_allow(scl_ok),
    .slave1_addr(s1_addr), .slave1_on(s1_on), .active(active));
  tsif_ctrl u_tsif_ctrl (.rif(rif), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .irq_out(irq_out));
  tsif_chk u_tsif_chk (.clk(clk), .reset_n(reset_n), .reg_wr(rif.reg_wr),
    .reg_rd(rif.reg_rd), .reg_addr(rif.reg_addr), .reg_wdata(rif.reg_wdata),
    .reg_rdata(rif.reg_rdata), .irq12(rif.irq12), .irq3(rif.irq3),
    .wake(rif.wake));
  initial begin
    forever #5 clk = ~clk;
  end
  // ---
  // compare, verdict and bus tasks
  // ---
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // a wait that ran out ends the run here
  task automatic limit(input int n);
    if (n >= 200) begin
      n_fail++;
      report_and_stop();
    end
  endtask
  // address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && n < 200);
    bready <= 1'b0;
    limit(n);
    chk(bresp, `TSIF_RESP_OKAY);
  endtask
  // the response code follows from the map, not from the design
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    int n;
    n = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 200);
    rready <= 1'b0;
    limit(n);
    chk(rdata, {24'h0, e});
    chk(rresp, (a > 8'h14) ? `TSIF_RESP_SLVERR : `TSIF_RESP_OKAY);
  endtask
  task automatic pulse(input logic [5:0] v);
    @(posedge clk);
    ev <= v;
    @(posedge clk);
    ev <= 6'h0;
  endtask
  // address phase then a run of bytes, stop left to the caller
  task automatic xfer(input tsif_pkg::tsif_slave_t s, input logic d,
                      input int nb);
    sl <= s;
    dir <= d;
    pulse(SA);
    repeat (nb) pulse(BY);
  endtask
  task automatic stop();
    pulse(SR);
    repeat (3) @(posedge clk);
  endtask
  // ---
  // main sequence
  // ---
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, busy, dir, err3} = '0;
    {awaddr, araddr, wdata, ev} = '0;
    sl = tsif_pkg::TSIF_SL1;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 6; i++) rd(8'(i * 4), 8'h00);
    rd(8'h18, 8'h00);
    wr(8'h04, 8'h04);
    rd(8'h04, 8'h04);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].r);
      chk(m12, rows[i].m12);
      chk(m3, rows[i].m3);
    end
    chk(wr_ok, 3'h4);
    chk({s1_addr, s1_on}, 8'ha5);
    wr(8'h00, 8'h1f);
    wr(8'h04, 8'h06);
    xfer(tsif_pkg::TSIF_SL1, 1'b0, 3);
    chk(rif.irq12, 1'b0);
    rd(8'h0c, 8'h03);
    stop();
    chk({rif.irq3, rif.irq12}, 2'b01);
    chk(refuse, 1'b1);
    rd(8'h04, 8'h06);
    busy <= 1'b1;
    rd(8'h08, 8'h08);
    busy <= 1'b0;
    rd(8'h08, 8'h08);
    rd(8'h08, 8'h00);
    chk(rif.irq12, 1'b0);
    wr(8'h04, 8'h04);
    chk(refuse, 1'b0);
    xfer(tsif_pkg::TSIF_SL3, 1'b1, 1);
    stop();
    chk({rif.irq3, rif.irq12, rif.wake}, 3'h5);
    rd(8'h14, 8'h02);
    rd(8'h08, 8'h04);
    wr(8'h04, 8'h0e);
    chk(wr_ok, 3'h6);
    xfer(tsif_pkg::TSIF_SL1, 1'b0, 2);
    stop();
    chk(rif.irq12, 1'b0);
    rd(8'h04, 8'h0c);
    rd(8'h0c, 8'h02);
    rd(8'h08, 8'h08);
    err3 <= 1'b1;
    pulse(MS);
    pulse(NK);
    repeat (3) @(posedge clk);
    chk({rif.irq3, scl_ok, irq_out}, 3'h5);
    rd(8'h08, 8'hc0);
    rd(8'h08, 8'h00);
    chk(scl_ok, 1'b1);
    wr(8'h04, 8'h07);
    rd(8'h04, 8'h05);
    pulse(WD);
    rd(8'h04, 8'h04);
    wr(8'h04, 8'h02);
    rd(8'h10, 8'h00);
    chk(active, 1'b0);
    wr(8'h00, 8'h1f);
    rd(8'h00, 8'h00);
    report_and_stop();
  end
endmodule
